// >>> include/lpcs_defines.vh
//
// Functional notes
// (R1) Input powerdown while running from the input clock stops the core clock.
// (R2) System holds chip reset low at least 20 us to restart the input.
// (R3) Chip reset low clears the input powerdown bit, restoring input power.
// (R4) Core leaves its reset state once the chip reset pin returns high.
// (R5) Firmware selects ring oscillator, waits two no-ops, then powers input down.
// (R6) Ring selected with input powered down keeps the core on slow ticks.
// (R7) Firmware powers input up, waits on the timer, then deselects the ring.
// (R8) Countdown timer flags expiry on reaching zero; firmware polls or interrupts.
// (R9) Firmware enables the synthesizer and waits for lock before selecting it.
// (R10) Sequences without synthesizer need synthesizer enable and select both zero.
// (R11) Sleep request stops the core, keeps interrupt logic; peripherals may stop.
// (R12) Writing 0x8000 to the loop-flag register sleeps; an interrupt wakes.
// (R13) Sleeping on the ring oscillator, wake-up waits for a ring tick.
// (R14) Firmware selects the ring oscillator before powering the input down.
// (R15) Power word 0x40F0 stops peripherals, selects slow; 0xC0F0 adds input off.
// (R16) Power word 0x0000 restores peripherals and the fast clock.
// (R17) Software stop halts all clocking; either wake pin or reset restarts.
// (R18) Wake pin zero clears clock halt; status bit cleared by writing 0x0010.
// (R19) With input powered down, wake-up is dominated by the input start-up.
// (R20) Timer control 0x0010 starts the countdown with countdown_divider two.
// (R21) Timer expiry sets status bit 8; writing 0x0100 clears it.
// (R22) Clock halt stops the core clock from any source; reset or pins clear it.
// (R23) Enabled wake pin clears clock halt without losing state or resetting.
// (R24) Ring and fast clock switching only at tick boundaries, no short pulses.
// (R25) Power word: bit 15 input powerdown, bit 14 ring select, 7:4 peripherals.
// (R26) Core state survives sleep and stop when woken by a pin.
`ifndef LPCS_DEFINES_VH
`define LPCS_DEFINES_VH

// register byte offsets
`define LPCS_OFF_POWER     8'h00
`define LPCS_OFF_LOOPFLAG  8'h04
`define LPCS_OFF_IRQSTAT   8'h08
`define LPCS_OFF_TMRCTRL   8'h0C
`define LPCS_OFF_TMRCOUNT  8'h10
`define LPCS_OFF_CLKSTAT   8'h14

// power control word fields
`define LPCS_PWR_INPUT_OFF 15
`define LPCS_PWR_RING_SEL  14
`define LPCS_PWR_HALT      13
`define LPCS_PWR_IRQ0_WEN  12
`define LPCS_PWR_IRQ1_WEN  11
`define LPCS_PWR_PERIPH_HI 7
`define LPCS_PWR_PERIPH_LO 4
`define LPCS_PWR_RESET     16'h0000

// loop-flag and status fields
`define LPCS_LOOP_SLEEP    15
`define LPCS_STAT_IRQ0     4
`define LPCS_STAT_IRQ1     5
`define LPCS_STAT_TIMER    8

// timer control fields
`define LPCS_TMR_RUN       4
`define LPCS_TMR_PRE_HI    3
`define LPCS_TMR_PRE_LO    0

// timing
`define LPCS_CLK_MHZ       125
`define LPCS_STARTUP_US    20
`define LPCS_STARTUP_CYC   (`LPCS_STARTUP_US * `LPCS_CLK_MHZ)
`define LPCS_RING_DIV      16

`endif

// >>> hdl/lpcs_sync.v
module lpcs_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             i_clk,
   input  wire             i_sys_rst,
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);

   reg [WIDTH-1:0] stage_one;
   reg [WIDTH-1:0] stage_two;

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         stage_one <= INIT;
         stage_two <= INIT;
      end else begin
         stage_one <= i_async;
         stage_two <= stage_one;
      end
   end

   assign o_sync = stage_two;

endmodule // lpcs_sync

// >>> hdl/lpcs_countdown.v
`include "lpcs_defines.vh"

module lpcs_countdown #(
   parameter CW = 16
) (
   input  wire          i_clk,
   input  wire          i_sys_rst,
   input  wire          i_tick,
   input  wire          i_run,
   input  wire [3:0]    i_countdown_divider,
   input  wire          i_load,
   input  wire [CW-1:0] i_load_value,
   output reg  [CW-1:0] o_count,
   output reg           o_expired
);

   reg [15:0] pre_count;
   reg        armed;
   wire [15:0] pre_limit;
   wire        pre_done;

   // countdown_divider code n divides by 2^(n+1): code 0 gives two
   assign pre_limit = (16'h0002 << i_countdown_divider) - 16'h0001;
   assign pre_done  = (pre_count >= pre_limit);

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_count   <= {CW{1'b0}};
         pre_count <= 16'h0000;
         armed     <= 1'b0;
         o_expired <= 1'b0;
      end else begin
         o_expired <= 1'b0;
         if (i_load) begin
            o_count   <= i_load_value;
            pre_count <= 16'h0000;
            armed     <= 1'b1;
         end else if (i_run && armed && i_tick) begin    // see (R20)
            if (pre_done) begin
               pre_count <= 16'h0000;
               if (o_count <= {{(CW-1){1'b0}}, 1'b1}) begin
                  o_count   <= {CW{1'b0}};
                  armed     <= 1'b0;
                  o_expired <= 1'b1;                      // see (R8)
               end else begin
                  o_count <= o_count - {{(CW-1){1'b0}}, 1'b1};
               end
            end else begin
               pre_count <= pre_count + 16'h0001;
            end
         end
      end
   end

endmodule // lpcs_countdown

// >>> hdl/lpcs_top.v
`include "lpcs_defines.vh"

module lpcs_top #(
   parameter RING_DIV    = `LPCS_RING_DIV,
   parameter STARTUP_CYC = `LPCS_STARTUP_CYC
) (
   input  wire        i_clk,
   input  wire        i_sys_rst,
   // apb slave
   input  wire [7:0]  i_paddr,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   // pins from system logic
   input  wire        i_chip_reset_low,
   input  wire        i_wake_irq_zero,
   input  wire        i_wake_irq_one,
   // clock and power controls
   output wire        o_core_clk_en,
   output wire        o_core_reset,
   output wire        o_input_power_on,
   output wire        o_ring_osc_power,
   output wire [3:0]  o_periph_disable,
   output wire        o_sleeping,
   output wire        o_halted
);

   ////////////////////////////////////////////////////////////////////////
   // decode helper

   function reg_hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         reg_hit = (addr == offset);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   wire [2:0] pins_sync;
   wire       chip_reset_low_s;
   wire       wake_zero_s;
   wire       wake_one_s;

   lpcs_sync #(
      .WIDTH (3),
      .INIT  (3'b001)
   ) u_pin_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_async   ({i_wake_irq_one, i_wake_irq_zero, i_chip_reset_low}),
      .o_sync    (pins_sync)
   );

   assign chip_reset_low_s = pins_sync[0];
   assign wake_zero_s      = pins_sync[1];
   assign wake_one_s       = pins_sync[2];

   reg  wake_zero_q;
   reg  wake_one_q;
   reg  chip_reset_q;
   wire wake_zero_rise;
   wire wake_one_rise;
   wire chip_reset_fall;

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wake_zero_q  <= 1'b0;
         wake_one_q   <= 1'b0;
         chip_reset_q <= 1'b1;
      end else begin
         wake_zero_q  <= wake_zero_s;
         wake_one_q   <= wake_one_s;
         chip_reset_q <= chip_reset_low_s;
      end
   end

   assign wake_zero_rise  = wake_zero_s & ~wake_zero_q;
   assign wake_one_rise   = wake_one_s & ~wake_one_q;
   assign chip_reset_fall = ~chip_reset_low_s & chip_reset_q;

   // core held in reset while the pin is low, runs after it rises
   wire pin_reset = ~chip_reset_low_s;
   assign o_core_reset = pin_reset;                      // see (R4)

   ////////////////////////////////////////////////////////////////////////
   // apb access

   wire apb_access = i_psel & i_penable;
   wire apb_write  = apb_access & i_pwrite;
   wire mapped     = reg_hit(i_paddr, `LPCS_OFF_POWER)
                   | reg_hit(i_paddr, `LPCS_OFF_LOOPFLAG)
                   | reg_hit(i_paddr, `LPCS_OFF_IRQSTAT)
                   | reg_hit(i_paddr, `LPCS_OFF_TMRCTRL)
                   | reg_hit(i_paddr, `LPCS_OFF_TMRCOUNT)
                   | reg_hit(i_paddr, `LPCS_OFF_CLKSTAT);

   wire wr_power  = apb_write & reg_hit(i_paddr, `LPCS_OFF_POWER);
   wire wr_loop   = apb_write & reg_hit(i_paddr, `LPCS_OFF_LOOPFLAG);
   wire wr_stat   = apb_write & reg_hit(i_paddr, `LPCS_OFF_IRQSTAT);
   wire wr_tctrl  = apb_write & reg_hit(i_paddr, `LPCS_OFF_TMRCTRL);
   wire wr_tcount = apb_write & reg_hit(i_paddr, `LPCS_OFF_TMRCOUNT);

   assign o_pready  = 1'b1;
   assign o_pslverr = apb_access & ~mapped;

   ////////////////////////////////////////////////////////////////////////
   // power control word

   reg  [15:0] power_word;
   wire        clock_input_powerdown = power_word[`LPCS_PWR_INPUT_OFF];
   wire        ring_osc_select       = power_word[`LPCS_PWR_RING_SEL];
   wire        clock_halt            = power_word[`LPCS_PWR_HALT];
   wire        irq_zero_wake_enable  = power_word[`LPCS_PWR_IRQ0_WEN];
   wire        irq_one_wake_enable   = power_word[`LPCS_PWR_IRQ1_WEN];
   wire        halt_wake;
   reg  [15:0] next_power_word;

   // any enabled wake pin releases the halt; state is kept intact
   assign halt_wake = (wake_zero_s & irq_zero_wake_enable)    // see (R18)
                    | (wake_one_s & irq_one_wake_enable);     // see (R23)

   always @* begin
      next_power_word = power_word;
      if (wr_power) begin
         next_power_word = i_pwdata[15:0];                    // see (R15)
         next_power_word[10:8] = 3'b000;
         next_power_word[3:0]  = 4'h0;
      end
      if (halt_wake) begin
         next_power_word[`LPCS_PWR_HALT] = 1'b0;              // see (R22)
      end
   end

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         power_word <= `LPCS_PWR_RESET;
      end else if (pin_reset) begin
         // reset pin clears input powerdown and the whole word
         power_word <= `LPCS_PWR_RESET;                       // see (R3)
      end else begin
         power_word <= next_power_word;                       // see (R16)
      end
   end

   assign o_periph_disable =
      power_word[`LPCS_PWR_PERIPH_HI:`LPCS_PWR_PERIPH_LO];    // see (R25)
   assign o_input_power_on = ~clock_input_powerdown;
   assign o_halted         = clock_halt;

   ////////////////////////////////////////////////////////////////////////
   // input start-up timing

   reg [15:0] startup_count;
   wire       input_stable = (startup_count >= STARTUP_CYC[15:0]);

   // fast clock not usable until the input has settled again
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         startup_count <= 16'h0000;
      end else if (clock_input_powerdown || chip_reset_fall) begin
         // a pin reset restarts the input, so its settling begins anew
         startup_count <= 16'h0000;                           // see (R19)
      end else if (!input_stable) begin
         startup_count <= startup_count + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ring oscillator and glitch-free source switch

   reg  [15:0] ring_div;
   reg         ring_active;
   wire        ring_powered;
   wire        ring_tick;
   wire        fast_ok;
   wire        src_tick;

   // in deep sleep the ring powers down in the same cycle as the core clock stops
   assign ring_powered = (ring_osc_select | ring_active) & ~clock_halt;
   assign ring_tick    = ring_powered & (ring_div == 16'h0000);
   assign fast_ok      = ~clock_input_powerdown & input_stable;

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ring_div <= 16'h0000;
      end else if (!ring_powered) begin
         ring_div <= 16'h0000;
      end else if (ring_div >= RING_DIV[15:0] - 16'h0001) begin
         ring_div <= 16'h0000;
      end else begin
         ring_div <= ring_div + 16'h0001;
      end
   end

   // selection moves to the ring at once and back to fast only on a ring tick,
   // which is also a fast edge, so neither source is ever cut short
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ring_active <= 1'b0;
      end else if (pin_reset) begin
         ring_active <= 1'b0;
      end else if (ring_active != ring_osc_select) begin
         if (ring_tick || (!ring_active && !clock_halt)) begin
            ring_active <= ring_osc_select;                   // see (R24)
         end
      end
   end

   // ring keeps the core going with the input off; fast needs the input
   assign src_tick = ring_active ? ring_tick                  // see (R6)
                                 : fast_ok;                   // see (R1)

   ////////////////////////////////////////////////////////////////////////
   // countdown timer

   reg  [15:0] timer_ctrl;
   reg  [15:0] timer_load;
   wire [15:0] countdown_count;
   wire        timer_expired;
   wire        timer_tick;

   // timer stops with the clocks and with its peripheral disable
   assign timer_tick = src_tick & ~clock_halt & ~o_periph_disable[0];

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         timer_ctrl <= 16'h0000;
         timer_load <= 16'h0000;
      end else if (pin_reset) begin
         timer_ctrl <= 16'h0000;
      end else begin
         if (wr_tctrl) begin
            timer_ctrl <= i_pwdata[15:0];                     // see (R20)
         end
         if (wr_tcount) begin
            timer_load <= i_pwdata[15:0];
         end
      end
   end

   lpcs_countdown #(
      .CW (16)
   ) u_countdown (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_tick       (timer_tick),
      .i_run        (timer_ctrl[`LPCS_TMR_RUN]),
      .i_countdown_divider   (timer_ctrl[`LPCS_TMR_PRE_HI:`LPCS_TMR_PRE_LO]),
      .i_load       (wr_tcount),
      .i_load_value (i_pwdata[15:0]),
      .o_count      (countdown_count),
      .o_expired    (timer_expired)
   );

   ////////////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear, set wins

   reg  [15:0] irq_status;
   reg  [15:0] next_irq_status;

   always @* begin
      next_irq_status = irq_status;
      if (wr_stat) begin
         next_irq_status = irq_status & ~i_pwdata[15:0];      // see (R21)
      end
      if (wake_zero_rise) begin
         next_irq_status[`LPCS_STAT_IRQ0] = 1'b1;             // see (R18)
      end
      if (wake_one_rise) begin
         next_irq_status[`LPCS_STAT_IRQ1] = 1'b1;
      end
      if (timer_expired) begin
         next_irq_status[`LPCS_STAT_TIMER] = 1'b1;            // see (R21)
      end
   end

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_status <= 16'h0000;
      end else if (pin_reset) begin
         irq_status <= 16'h0000;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sleep request

   reg  sleep_req;
   wire sleep_wake = wake_zero_rise | wake_one_rise | timer_expired;
   reg  wake_held;

   // the wake is held until a source tick, so on the ring the
   // latency is up to one ring period
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sleep_req <= 1'b0;
         wake_held <= 1'b0;
      end else if (pin_reset) begin
         sleep_req <= 1'b0;
         wake_held <= 1'b0;
      end else if (sleep_req) begin
         if (sleep_wake) begin
            wake_held <= 1'b1;
         end
         if ((sleep_wake || wake_held) && src_tick) begin
            sleep_req <= 1'b0;                                // see (R13)
            wake_held <= 1'b0;
         end
      end else if (wr_loop && i_pwdata[`LPCS_LOOP_SLEEP]) begin
         // cannot enter sleep without a running processor clock
         if (!clock_halt && (src_tick || fast_ok || ring_active)) begin
            sleep_req <= 1'b1;                                // see (R12)
         end
      end
   end

   assign o_sleeping = sleep_req;                             // see (R11)

   ////////////////////////////////////////////////////////////////////////
   // core clock enable

   // halt and sleep only gate the enable, nothing in the core is reset
   assign o_core_clk_en = src_tick & ~clock_halt              // see (R17)
                        & ~sleep_req & ~pin_reset;            // see (R26)
   assign o_ring_osc_power = ring_powered;

   ////////////////////////////////////////////////////////////////////////
   // read data

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_prdata <= 32'h00000000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         case (i_paddr)
            `LPCS_OFF_POWER: begin
               o_prdata <= {16'h0000, power_word};
            end
            `LPCS_OFF_LOOPFLAG: begin
               o_prdata <= {16'h0000, sleep_req, 15'h0000};
            end
            `LPCS_OFF_IRQSTAT: begin
               o_prdata <= {16'h0000, irq_status};
            end
            `LPCS_OFF_TMRCTRL: begin
               o_prdata <= {16'h0000, timer_ctrl};
            end
            `LPCS_OFF_TMRCOUNT: begin
               o_prdata <= {16'h0000, countdown_count};
            end
            `LPCS_OFF_CLKSTAT: begin
               o_prdata <= {26'h0000000, ring_powered, clock_halt,
                            sleep_req, input_stable, ring_active,
                            fast_ok};
            end
            default: begin
               o_prdata <= 32'h00000000;
            end
         endcase
      end
   end

endmodule // lpcs_top

// >>> verification/lpcs_props.sv
`include "lpcs_defines.vh"
module lpcs_props #(
   parameter RING_DIV    = 16,
   parameter STARTUP_CYC = 2500
) (
   input wire        i_clk,
   input wire        i_sys_rst,
   input wire [7:0]  i_paddr,
   input wire        i_psel,
   input wire        i_penable,
   input wire        i_pwrite,
   input wire [31:0] i_pwdata,
   input wire        i_chip_reset_low,
   input wire        i_wake_irq_zero,
   input wire        o_core_clk_en,
   input wire        o_core_reset,
   input wire        o_input_power_on,
   input wire [3:0]  o_periph_disable,
   input wire        o_sleeping,
   input wire        o_halted
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic pw_wr;
   logic ring_sel;
   logic irq0_wen;
   assign pw_wr = i_psel && i_penable && i_pwrite
                  && i_paddr == `LPCS_OFF_POWER;
   // shadow of the power word bits wake pin zero and the clock mux act on
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ring_sel <= 1'b0;
         irq0_wen <= 1'b0;
      end else if (o_core_reset) begin
         ring_sel <= 1'b0;
         irq0_wen <= 1'b0;
      end else if (pw_wr) begin
         ring_sel <= i_pwdata[14];
         irq0_wen <= i_pwdata[12];
      end
   end
   sequence s_pw_write;
      pw_wr && !o_core_reset;
   endsequence
   sequence s_pin_low;
      !i_chip_reset_low [*3];
   endsequence
   chk_input_power: assert property (s_pw_write |=>
      o_input_power_on == !$past(i_pwdata[15])) else $error("input power");
   chk_periph_bits: assert property (s_pw_write |=>
      o_periph_disable == $past(i_pwdata[7:4])) else $error("periph bits");
   chk_halt_set: assert property (s_pw_write ##0
      (i_pwdata[13] && !i_wake_irq_zero) |=> o_halted) else $error("halt");
   chk_halt_gate: assert property (o_halted |-> !o_core_clk_en)
      else $error("clock while halted");
   chk_sleep_gate: assert property (o_sleeping ##1 o_sleeping
      |-> !$past(o_core_clk_en)) else $error("clock while asleep");
   chk_wake_halt: assert property (o_halted && irq0_wen
      && i_wake_irq_zero |-> ##[1:4] !o_halted) else $error("wake pin");
   chk_pin_reset: assert property (s_pin_low |->
      o_core_reset ##1 o_input_power_on) else $error("pin reset");
   chk_startup_wait: assert property ($fell(i_sys_rst) |->
      !o_core_clk_en [*8]) else $error("startup wait");
   chk_ring_rate: assert property (ring_sel && o_core_clk_en |=>
      !o_core_clk_en) else $error("ring rate");
endmodule // lpcs_props

bind lpcs_top lpcs_props #(.RING_DIV(RING_DIV), .STARTUP_CYC(STARTUP_CYC))
   u_props (.i_clk, .i_sys_rst, .i_paddr, .i_psel, .i_penable, .i_pwrite,
   .i_pwdata, .i_chip_reset_low, .i_wake_irq_zero, .o_core_clk_en,
   .o_core_reset, .o_input_power_on, .o_periph_disable, .o_sleeping,
   .o_halted);

// >>> verification/lpcs_sys_model.sv
module lpcs_sys_model #(
   parameter HOLD_CYC = 16
) (
   input  wire  i_clk,
   output logic o_chip_reset_low,
   output logic o_wake_irq_zero,
   output logic o_wake_irq_one
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_chip_reset_low = 1'b1;
      o_wake_irq_zero = 1'b0;
      o_wake_irq_one = 1'b0;
   end
   // short pulses would restart before the input reaches its bias point
   task pulse_reset(input int extra);
      @(posedge i_clk);
      o_chip_reset_low <= 1'b0;
      repeat (HOLD_CYC + extra) @(posedge i_clk);
      o_chip_reset_low <= 1'b1;
   endtask
   task wake(input bit one, input int len);
      @(posedge i_clk);
      if (one) o_wake_irq_one <= 1'b1;
      else o_wake_irq_zero <= 1'b1;
      repeat (len) @(posedge i_clk);
      o_wake_irq_one <= 1'b0;
      o_wake_irq_zero <= 1'b0;
   endtask
endmodule // lpcs_sys_model

// >>> verification/low_power_clock_sequencer_tb.sv
`include "lpcs_defines.vh"
module low_power_clock_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RDIV = 4;
   localparam int SCYC = 16;
   localparam logic [7:0] PW = `LPCS_OFF_POWER;
   localparam logic [7:0] LF = `LPCS_OFF_LOOPFLAG;
   localparam logic [7:0] IS = `LPCS_OFF_IRQSTAT;
   logic        i_clk, i_sys_rst, i_psel, i_penable, i_pwrite;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd, en;
   logic        o_pready, o_pslverr, o_core_clk_en, o_core_reset, er;
   logic        o_input_power_on, o_ring_osc_power, o_sleeping, o_halted;
   logic        i_chip_reset_low, i_wake_irq_zero, i_wake_irq_one;
   logic [3:0]  o_periph_disable;
   int          err_count, total_checks, n, c;

   lpcs_top #(.RING_DIV(RDIV), .STARTUP_CYC(SCYC)) dut (.i_clk, .i_sys_rst,
      .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata, .o_prdata,
      .o_pready, .o_pslverr, .i_chip_reset_low, .i_wake_irq_zero,
      .i_wake_irq_one, .o_core_clk_en, .o_core_reset, .o_input_power_on,
      .o_ring_osc_power, .o_periph_disable, .o_sleeping, .o_halted);
   lpcs_sys_model #(.HOLD_CYC(SCYC)) sysm (.i_clk,
      .o_chip_reset_low(i_chip_reset_low), .o_wake_irq_zero(i_wake_irq_zero),
      .o_wake_irq_one(i_wake_irq_one));

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   ////////////////////////////////////////
   task chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge i_clk);
      i_paddr <= a;
      i_pwrite <= w;
      i_pwdata <= d;
      i_psel <= 1'b1;
      @(posedge i_clk);
      i_penable <= 1'b1;
      // the wait for the answer ends once o_pready is high, else only the watchdog ends it
      do begin
         @(posedge i_clk);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(nm, rd, exp);
   endtask
   task pulses(input int len);
      c = 0;
      repeat (len) begin
         @(negedge i_clk);
         c += (o_core_clk_en === 1'b1);
      end
   endtask
   ////////////////////////////////////////
   task t_reset;
      rdc("power rst", PW, 32'h0);
      repeat (SCYC + 8) @(negedge i_clk);
      chk("input on", o_input_power_on, 1'b1);
      pulses(8);
      chk("fast clk", c, 8);
      xfer(8'h18, 1'b0, 32'h0);
      chk("unmapped", {er, rd[30:0]}, 32'h80000000);
   endtask
   task t_ring;
      wr(PW, 32'h40F0);
      repeat (2) @(posedge i_clk);
      wr(PW, 32'hC0F0);
      @(negedge i_clk);
      chk("input off", o_input_power_on, 1'b0);
      chk("periph off", o_periph_disable, 4'hF);
      chk("ring power", o_ring_osc_power, 1'b1);
      pulses(40);
      chk("slow clk", c, 40 / RDIV);
      // no synthesizer here: enable and select stay zero, no lock wait
      wr(PW, 32'h4000);
      wr(`LPCS_OFF_TMRCOUNT, 32'h20);
      wr(`LPCS_OFF_TMRCTRL, 32'h10);
      n = 0;
      do begin
         xfer(IS, 1'b0, 32'h0);
         n++;
      end while (rd[8] !== 1'b1 && n < 400);
      chk("timer span", n * 3 >= 64 * RDIV - 12, 1);
      chk("timer flag", rd, 32'h100);
      wr(IS, 32'h100);
      rdc("timer clr", IS, 32'h0);
      wr(PW, 32'h0);
      repeat (2 * RDIV + 4) @(negedge i_clk);
      pulses(8);
      chk("fast back", c, 8);
   endtask
   task t_sleep;
      for (int i = 0; i < 2; i++) begin
         wr(PW, i ? 32'h40F0 : 32'h00F0);
         repeat (2 * RDIV) @(posedge i_clk);
         wr(LF, 32'h8000);
         @(negedge i_clk);
         chk("asleep", o_sleeping, 1'b1);
         pulses(20);
         chk("sleep clk", c, 0);
         sysm.wake(1'b0, 12);
         @(negedge i_clk);
         chk("awake", o_sleeping, 1'b0);
         pulses(8);
         chk("wake clk", c, i ? 8 / RDIV : 8);
         rdc("wake stat", IS, 32'h10);
         wr(IS, 32'h10);
         rdc("stat clr", IS, 32'h0);
      end
      wr(PW, 32'h0);
   endtask
   task t_stop;
      for (int i = 0; i < 2; i++) begin
         en = i ? 32'h0800 : 32'h1000;
         wr(PW, 32'h4000);
         repeat (2) @(posedge i_clk);
         wr(PW, 32'hC000 | en);
         wr(PW, 32'hE000 | en);
         @(negedge i_clk);
         chk("halted", o_halted, 1'b1);
         chk("ring off", o_ring_osc_power, 1'b0);
         pulses(20);
         chk("stop clk", c, 0);
         sysm.wake(i[0], 8);
         @(negedge i_clk);
         chk("resumed", o_halted, 1'b0);
         rdc("state kept", PW, 32'hC000 | en);
         rdc("pin stat", IS, i ? 32'h20 : 32'h10);
         wr(IS, 32'h30);
         wr(PW, 32'h4000);
         repeat (SCYC + 4) @(posedge i_clk);
         wr(PW, 32'h0);
      end
   endtask
   task t_pinreset;
      // ring must hand back to the fast clock before the input goes off
      repeat (2 * RDIV + 4) @(posedge i_clk);
      wr(PW, 32'h8000);
      pulses(10);
      chk("input off stop", c, 0);
      fork
         sysm.pulse_reset(4);
         begin
            repeat (6) @(negedge i_clk);
            chk("core reset", o_core_reset, 1'b1);
         end
      join
      repeat (4) @(negedge i_clk);
      chk("core free", o_core_reset, 1'b0);
      chk("input back", o_input_power_on, 1'b1);
      rdc("power clr", PW, 32'h0);
      repeat (SCYC + 8) @(negedge i_clk);
      pulses(8);
      chk("restart clk", c, 8);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      i_sys_rst = 1'b1;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 8'h00;
      i_pwdata = 32'h0;
      err_count = 0;
      total_checks = 0;
      repeat (8) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_reset;
      t_ring;
      t_sleep;
      t_stop;
      t_pinreset;
      summarize;
   end
   // whole run needs under a thousand cycles
   initial begin
      repeat (50000) @(posedge i_clk);
      err_count++;
      summarize;
   end
endmodule // low_power_clock_sequencer_tb
